// >>> core/rsse_pkg.sv
// package: opcodes, flag layout, phases, reset values for the four-opcode executor
package rsse_pkg;
   localparam logic [5:0]  OPC_ROTATE_HI   = 6'h10;   // 0100 00da
   localparam logic [6:0]  OPC_FILL_HI     = 7'h34;   // 0110 100a
   localparam logic [5:0]  OPC_SUBTRACT_HI = 6'h15;   // 0101 01da
   localparam logic [15:0] OPC_SLEEP       = 16'h0003;
   localparam logic [7:0]  FILL_VALUE      = 8'hff;
   localparam logic [7:0]  INDEXED_LIMIT   = 8'h5f;   // 95
   localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;   // access bank low/high split
   localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
   localparam logic [7:0]  W_RESET         = 8'h00;
   localparam logic [3:0]  BANK_RESET      = 4'h0;
   localparam logic [4:0]  STATUS_RESET    = 5'h00;
   // flag bit positions within the status word
   localparam int FLAG_C  = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N  = 4;
   localparam int EVT_DONE   = 0;
   localparam int EVT_SLEEP  = 1;
   localparam int EVT_WAKE   = 2;
   localparam int EVT_COUNT  = 3;

   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE   = 2'b11
   } rsse_phase_type;

   typedef enum logic [2:0] {
      OP_NONE     = 3'b000,
      OP_ROTATE   = 3'b001,
      OP_FILL     = 3'b010,
      OP_SUBTRACT = 3'b011,
      OP_SLEEP    = 3'b100
   } rsse_op_type;

   // decoded instruction fields
   typedef struct packed {
      rsse_op_type op;
      logic        dest_file;
      logic        banked;
      logic [7:0]  file_addr;
   } rsse_decode_type;

   // file-memory access request
   typedef struct packed {
      logic       write;
      logic [3:0] bank;
      logic [7:0] offset;
      logic [7:0] data;
   } rsse_mem_type;
endpackage

// >>> core/rsse_decoder.sv
// opcode decoder for the four supported one-word instructions
`timescale 1ns/100ps
module rsse_decoder import rsse_pkg::*; (
   input  wire logic [15:0]     opcode,
   output rsse_decode_type      fields
);
   // opcode match; unsupported codes decode as no operation
   always_comb begin
      fields.op        = OP_NONE;
      fields.dest_file = opcode[9];
      fields.banked    = opcode[8];
      fields.file_addr = opcode[7:0];
      if (opcode == OPC_SLEEP) begin
         fields.op = OP_SLEEP;
      end else if (opcode[15:10] == OPC_ROTATE_HI) begin
         fields.op = OP_ROTATE;
      end else if (opcode[15:10] == OPC_SUBTRACT_HI) begin
         fields.op = OP_SUBTRACT;
      end else if (opcode[15:9] == OPC_FILL_HI) begin
         fields.op        = OP_FILL;
         fields.dest_file = 1'b1;
      end
   end
endmodule // rsse_decoder

// >>> core/rsse_alu.sv
// arithmetic unit: rotate right plain and subtract with borrow
`timescale 1ns/100ps
module rsse_alu import rsse_pkg::*; (
   input  wire logic [7:0]  w_val,
   input  wire logic [7:0]  f_val,
   input  wire logic        carry_in,
   input  wire logic        do_rotate,
   output logic [7:0]       result,
   output logic             carry_out,
   output logic             half_out,
   output logic             ovf_out
);
   logic [8:0] diff;
   logic [4:0] low_diff;

   // borrow is the inverted carry; carry set means no borrow
   always_comb begin
      diff      = {1'b0, w_val} - {1'b0, f_val} - {8'h00, ~carry_in};
      low_diff  = {1'b0, w_val[3:0]} - {1'b0, f_val[3:0]} - {4'h0, ~carry_in};
      carry_out = ~diff[8];
      half_out  = ~low_diff[4];
      ovf_out   = (w_val[7] != f_val[7]) && (diff[7] != w_val[7]);
      if (do_rotate) begin
         result = {f_val[0], f_val[7:1]};
      end else begin
         result = diff[7:0];
      end
   end
endmodule // rsse_alu

// >>> core/rsse_exec.sv
// executor for rotate-right, fill-ones, sleep and subtract-with-borrow instructions
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
module rsse_exec import rsse_pkg::*; #(
   parameter int MEM_BANKS   = 16,
   parameter int WDT_WIDTH   = 8,
   parameter int POST_WIDTH  = 16
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        ext_set_enable,
   input  wire logic [7:0]  index_base,
   input  wire logic        bank_load,
   input  wire logic [3:0]  bank_value,
   input  wire logic        w_load,
   input  wire logic [7:0]  w_value,
   input  wire logic        wdt_tick,
   input  wire logic        wake_other,
   input  wire logic [3:0]  dbg_bank,
   input  wire logic [7:0]  dbg_addr,
   input  wire logic [2:0]  irq_enable,
   input  wire logic        irq_clear_wr,
   input  wire logic [2:0]  irq_clear,
   output logic             instr_ready,
   output logic             instr_done,
   output logic [7:0]       w_out,
   output logic [4:0]       status_out,
   output logic             power_down_flag,
   output logic             time_out_flag,
   output logic             osc_run,
   output logic             sleeping,
   output logic [WDT_WIDTH-1:0]  watchdog_counter,
   output logic [POST_WIDTH-1:0] watchdog_post,
   output logic [7:0]       dbg_data,
   output logic [2:0]       irq_status,
   output logic             irq_out
);
   rsse_phase_type  phase_reg;
   logic            busy_reg;
   logic [15:0]     opcode_reg;
   rsse_decode_type fields;
   logic [7:0]      general_purpose_regs [MEM_BANKS*256];
   logic [7:0]      w_reg;
   logic [3:0]      bank_select_reg;
   logic [4:0]      status_reg;
   logic [7:0]      operand_reg;
   logic [7:0]      result_reg;
   logic            c_next;
   logic            dc_next;
   logic            ov_next;
   logic [7:0]      alu_result;
   logic [11:0]     eff_addr;
   logic [7:0]      indexed_sum;
   logic            sleep_reg;
   logic [2:0]      event_pulse;
   logic            wdt_expired;

   rsse_decoder u_decoder (
      .opcode (opcode_reg),
      .fields (fields)
   );

   rsse_alu u_alu (
      .w_val     (w_reg),
      .f_val     (operand_reg),
      .carry_in  (status_reg[FLAG_C]),
      .do_rotate (fields.op == OP_ROTATE),
      .result    (alu_result),
      .carry_out (c_next),
      .half_out  (dc_next),
      .ovf_out   (ov_next)
   );

   // effective address of the file operand
   // the indexed sum wraps within bank 0; a carry past 255 is dropped on purpose
   always_comb begin
      indexed_sum = index_base + fields.file_addr;
      if (fields.banked) begin
         eff_addr = {bank_select_reg, fields.file_addr};
      end else if (ext_set_enable && fields.file_addr <= INDEXED_LIMIT) begin
         eff_addr = {4'h0, indexed_sum};
      end else if (fields.file_addr < ACCESS_SPLIT) begin
         eff_addr = {4'h0, fields.file_addr};
      end else begin
         eff_addr = {ACCESS_HI_BANK, fields.file_addr};
      end
   end

   assign wdt_expired = &watchdog_counter;

   // a word offered while busy or asleep is dropped, not queued; the
   // offering side watches instr_ready to know when to present one
   // four-phase instruction sequencer; new word only accepted while idle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         phase_reg  <= PH_DECODE;
         busy_reg   <= 1'b0;
         opcode_reg <= 16'h0000;
      end else if (!busy_reg) begin
         if (instr_valid && !sleep_reg) begin
            busy_reg   <= 1'b1;
            opcode_reg <= instr_word;
            phase_reg  <= PH_READ;
         end
      end else begin
         unique case (phase_reg)
            PH_DECODE: begin
               phase_reg <= PH_READ;
            end
            PH_READ: begin
               phase_reg <= PH_PROCESS;
            end
            PH_PROCESS: begin
               phase_reg <= PH_WRITE;
            end
            PH_WRITE: begin
               phase_reg <= PH_DECODE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // operand read and processing phases
   // the operand is latched once so the alu inputs hold still up to the
   // write phase, where the flags are taken without another stage
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         operand_reg <= 8'h00;
         result_reg  <= 8'h00;
      end else if (busy_reg && phase_reg == PH_READ) begin
         operand_reg <= general_purpose_regs[eff_addr];
      end else if (busy_reg && phase_reg == PH_PROCESS) begin
         result_reg <= (fields.op == OP_FILL) ? FILL_VALUE : alu_result;
      end
   end

   // file memory write and debug read port; memory has no reset by design
   // debug read is registered so the array's two read ports, operand and debug, are both clocked
   always_ff @(posedge core_clk) begin
      if (busy_reg && phase_reg == PH_WRITE && fields.dest_file &&
          (fields.op == OP_ROTATE || fields.op == OP_SUBTRACT || fields.op == OP_FILL)) begin
         general_purpose_regs[eff_addr] <= result_reg;
      end
      dbg_data <= general_purpose_regs[{dbg_bank, dbg_addr}];
   end

   // working register
   // an instruction's W write wins over an outside load; loads are only
   // honoured while idle, so one offered during an instruction is lost
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         w_reg <= W_RESET;
      end else if (busy_reg && phase_reg == PH_WRITE && !fields.dest_file &&
                   (fields.op == OP_ROTATE || fields.op == OP_SUBTRACT)) begin
         w_reg <= result_reg;
      end else if (w_load && !busy_reg) begin
         w_reg <= w_value;
      end
   end

   // bank select register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bank_select_reg <= BANK_RESET;
      end else if (bank_load && !busy_reg) begin
         bank_select_reg <= bank_value;
      end
   end

   // arithmetic flags written in the last phase
   // carry, half carry and overflow come live from the alu here, which is
   // safe because its inputs are the latched operand, W and the old carry
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status_reg <= STATUS_RESET;
      end else if (busy_reg && phase_reg == PH_WRITE) begin
         if (fields.op == OP_ROTATE) begin
            status_reg[FLAG_N] <= result_reg[7];
            status_reg[FLAG_Z] <= (result_reg == 8'h00);
         end else if (fields.op == OP_SUBTRACT) begin
            // all five flags; carry taken live from the alu in the write phase
            status_reg[FLAG_N]  <= result_reg[7];
            status_reg[FLAG_Z]  <= (result_reg == 8'h00);
            status_reg[FLAG_C]  <= c_next;
            status_reg[FLAG_DC] <= dc_next;
            status_reg[FLAG_OV] <= ov_next;
         end
      end
   end

   // power-down, time-out and sleep state
   // a watchdog wake outranks an outside wake so the time-out flag is
   // cleared whenever the watchdog was the cause, even if both coincide
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         power_down_flag <= 1'b1;
         time_out_flag   <= 1'b1;
         sleep_reg       <= 1'b0;
      end else if (busy_reg && phase_reg == PH_WRITE && fields.op == OP_SLEEP) begin
         power_down_flag <= 1'b0;
         time_out_flag   <= 1'b1;
         sleep_reg       <= 1'b1;
      end else if (sleep_reg && wdt_tick && wdt_expired) begin
         time_out_flag <= 1'b0;
         sleep_reg     <= 1'b0;
      end else if (sleep_reg && wake_other) begin
         sleep_reg <= 1'b0;
      end
   end

   // watchdog counter and postscaler
   // the clear sits in the process phase, so a tick in the write phase may
   // already count again; expiry while awake only wraps the counter
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         watchdog_counter <= '0;
         watchdog_post    <= '0;
      end else if (busy_reg && phase_reg == PH_PROCESS && fields.op == OP_SLEEP) begin
         watchdog_counter <= '0;
         watchdog_post    <= '0;
      end else if (wdt_tick) begin
         watchdog_post <= watchdog_post + 1'b1;
         if (&watchdog_post) begin
            watchdog_counter <= watchdog_counter + 1'b1;
         end
      end
   end

   // event pulses: instruction done, sleep entered, watchdog wake
   always_comb begin
      event_pulse            = 3'b000;
      event_pulse[EVT_DONE]  = busy_reg && phase_reg == PH_WRITE;
      event_pulse[EVT_SLEEP] = busy_reg && phase_reg == PH_WRITE && fields.op == OP_SLEEP;
      event_pulse[EVT_WAKE]  = sleep_reg && wdt_tick && wdt_expired;
   end

   // sticky status, set wins over a clear in the same cycle
   // so no event is lost between software reading the status and
   // writing its clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_status <= 3'b000;
      end else begin
         irq_status <= (irq_status & ~(irq_clear_wr ? irq_clear : 3'b000)) | event_pulse;
      end
   end

   // registered outputs
   // every port is a flop so boundary timing does not depend on the depth
   // of the decode and alu logic inside
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_out     <= 1'b0;
         instr_ready <= 1'b0;
         instr_done  <= 1'b0;
         w_out       <= W_RESET;
         status_out  <= STATUS_RESET;
         osc_run     <= 1'b1;
         sleeping    <= 1'b0;
      end else begin
         irq_out     <= |(irq_status & irq_enable);
         instr_ready <= !busy_reg && !sleep_reg && !instr_valid;
         instr_done  <= event_pulse[EVT_DONE];
         w_out       <= w_reg;
         status_out  <= status_reg;
         osc_run     <= !sleep_reg;
         sleeping    <= sleep_reg;
      end
   end
endmodule // rsse_exec

// >>> verif/rsse_exec_chk.sv
// checker: timing and flag relations at the executor's ports
`timescale 1ns/100ps
module rsse_exec_chk import rsse_pkg::*; #(
   parameter int WDT_WIDTH  = 8,
   parameter int POST_WIDTH = 16
) (
   input wire logic                  core_clk,
   input wire logic                  resetn,
   input wire logic                  instr_valid,
   input wire logic [15:0]           instr_word,
   input wire logic                  wdt_tick,
   input wire logic [2:0]            irq_enable,
   input wire logic                  instr_done,
   input wire logic [4:0]            status_out,
   input wire logic                  power_down_flag,
   input wire logic                  time_out_flag,
   input wire logic                  osc_run,
   input wire logic                  sleeping,
   input wire logic [WDT_WIDTH-1:0]  watchdog_counter,
   input wire logic [POST_WIDTH-1:0] watchdog_post,
   input wire logic [2:0]            irq_status,
   input wire logic                  irq_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // completion of a fill or rotate, four edges after the word was taken
   sequence s_fill_done;
      instr_done && ($past(instr_word[15:9], 4) == OPC_FILL_HI);
   endsequence
   sequence s_rot_done;
      instr_done && ($past(instr_word[15:10], 4) == OPC_ROTATE_HI);
   endsequence
   // sleep written: power-down falls, clock stops within one more edge
   sequence s_sleep_entry;
      $fell(power_down_flag);
   endsequence

   AST_DONE_CAUSE: assert property (instr_done |-> $past(instr_valid, 4))
      else $error("done without an instruction taken four cycles before");
   AST_DONE_PULSE: assert property (instr_done |=> !instr_done)
      else $error("done longer than one cycle");
   AST_FILL_FLAGS: assert property (s_fill_done |-> ##1 status_out == $past(status_out, 3))
      else $error("fill-ones changed the flags");
   AST_ROT_KEEP: assert property (s_rot_done |-> ##1 (status_out & 5'h0b) == ($past(status_out, 3) & 5'h0b))
      else $error("rotate changed carry, half carry or overflow");
   AST_SLEEP_STOP: assert property (s_sleep_entry |-> time_out_flag ##[0:1] (sleeping && !osc_run))
      else $error("sleep entry without time-out set or clock stop");
   AST_WDT_CLEAR: assert property (s_sleep_entry and !$past(wdt_tick) |-> watchdog_counter == '0 && watchdog_post == '0)
      else $error("watchdog not cleared by sleep");
   AST_WAKE_TO: assert property ($fell(time_out_flag) |-> ($past(wdt_tick) || $past(wdt_tick, 2)) ##[0:1] !sleeping)
      else $error("time-out cleared without watchdog wake");
   AST_ASLEEP_IDLE: assert property (sleeping && $past(sleeping) |-> !instr_done)
      else $error("instruction completed while asleep");
   AST_IRQ_LEVEL: assert property (irq_out == $past(|(irq_status & irq_enable)))
      else $error("interrupt level does not follow enabled status");
endmodule // rsse_exec_chk

bind rsse_exec rsse_exec_chk #(.WDT_WIDTH(WDT_WIDTH), .POST_WIDTH(POST_WIDTH)) i_rsse_exec_chk (
   .core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_word(instr_word),
   .wdt_tick(wdt_tick), .irq_enable(irq_enable), .instr_done(instr_done), .status_out(status_out),
   .power_down_flag(power_down_flag), .time_out_flag(time_out_flag), .osc_run(osc_run),
   .sleeping(sleeping), .watchdog_counter(watchdog_counter), .watchdog_post(watchdog_post),
   .irq_status(irq_status), .irq_out(irq_out));

// >>> verif/rsse_exec_tb_top.sv
// testbench: drives the executor's ports and checks results against a reference
`timescale 1ns/100ps
module rsse_exec_tb_top import rsse_pkg::*;;
   logic        core_clk, resetn, instr_valid, ext_set_enable, bank_load, w_load, wdt_tick, wake_other;
   logic        irq_clear_wr, instr_ready, instr_done, power_down_flag, time_out_flag, osc_run, sleeping, irq_out;
   logic [15:0] instr_word;
   logic [7:0]  index_base, w_value, dbg_addr, w_out, dbg_data, m, r;
   logic [3:0]  bank_value, dbg_bank;
   logic [2:0]  irq_enable, irq_clear, irq_status;
   logic [4:0]  status_out, st;
   logic [1:0]  watchdog_counter, watchdog_post;
   int          failures, n_tests;
   logic [7:0]  wv [5] = '{8'h05, 8'h80, 8'h7f, 8'h05, 8'h07};
   logic [7:0]  fa [5] = '{8'h70, 8'h40, 8'h05, 8'h5f, 8'h60};
   logic        ex [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

   // short watchdog widths keep the sleep wake-up within a few dozen cycles
   rsse_exec #(.WDT_WIDTH(2), .POST_WIDTH(2)) i_rsse_exec (
      .core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_word(instr_word),
      .ext_set_enable(ext_set_enable), .index_base(index_base), .bank_load(bank_load),
      .bank_value(bank_value), .w_load(w_load), .w_value(w_value), .wdt_tick(wdt_tick),
      .wake_other(wake_other), .dbg_bank(dbg_bank), .dbg_addr(dbg_addr), .irq_enable(irq_enable),
      .irq_clear_wr(irq_clear_wr), .irq_clear(irq_clear), .instr_ready(instr_ready),
      .instr_done(instr_done), .w_out(w_out), .status_out(status_out),
      .power_down_flag(power_down_flag), .time_out_flag(time_out_flag), .osc_run(osc_run),
      .sleeping(sleeping), .watchdog_counter(watchdog_counter), .watchdog_post(watchdog_post),
      .dbg_data(dbg_data), .irq_status(irq_status), .irq_out(irq_out));

   // clock of 40 ns
   always #20 core_clk = ~core_clk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one word offered for one cycle, then outputs given two edges to settle
   task automatic run_instr(input logic [15:0] word);
      int n;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr_word  <= word;
      @(posedge core_clk);
      instr_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (instr_done !== 1'b1 && n < 8);
      chk(instr_done, 1'b1);
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   // file memory peek; read data is registered one cycle behind the address
   task automatic peek(input logic [3:0] b, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      dbg_bank <= b;
      dbg_addr <= a;
      repeat (2) @(posedge core_clk);
      #1;
      chk(dbg_data, exp);
   endtask

   // reference subtract with borrow: returns flags and result
   function automatic logic [12:0] sub_ref(input logic [7:0] w, input logic [7:0] f, input logic c);
      logic [8:0] d;
      logic [4:0] h;
      logic [4:0] s;
      d = {1'b0, w} - {1'b0, f} - {8'h00, !c};
      h = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, !c};
      s[FLAG_C] = !d[8];
      s[FLAG_DC] = !h[4];
      s[FLAG_Z] = (d[7:0] == 8'h00);
      s[FLAG_OV] = (w[7] != f[7]) && (d[7] != w[7]);
      s[FLAG_N] = d[7];
      return {s, d[7:0]};
   endfunction

   // hang guard, far beyond the length of the sequence
   initial begin
      #(40 * 4000);
      failures++;
      tally_and_finish();
   end

   initial begin
      {core_clk, resetn, instr_valid, ext_set_enable, bank_load, w_load, wdt_tick, wake_other} = '0;
      {instr_word, w_value, bank_value, dbg_bank, dbg_addr, irq_clear_wr, irq_clear} = '0;
      index_base = 8'h20;
      irq_enable = 3'b001;
      failures = 0;
      n_tests = 0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      chk({power_down_flag, time_out_flag, osc_run, sleeping}, 4'b1110);
      chk(status_out, STATUS_RESET);
      @(posedge core_clk);
      bank_load <= 1'b1;
      bank_value <= 4'h2;
      @(posedge core_clk);
      bank_load <= 1'b0;
      run_instr({OPC_FILL_HI, 1'b1, 8'h10});
      chk(status_out, STATUS_RESET);
      chk(instr_ready, 1'b1);
      peek(4'h2, 8'h10, FILL_VALUE);
      chk(irq_out, 1'b1);
      m = FILL_VALUE;
      st = STATUS_RESET;
      // chained subtracts into the same file byte, borrow carried along
      foreach (wv[i]) begin
         @(posedge core_clk);
         w_load <= 1'b1;
         w_value <= wv[i];
         @(posedge core_clk);
         w_load <= 1'b0;
         {st, m} = sub_ref(wv[i], m, st[FLAG_C]);
         run_instr({OPC_SUBTRACT_HI, 1'b1, 1'b1, 8'h10});
         chk(status_out, st);
         chk(w_out, wv[i]);
         peek(4'h2, 8'h10, m);
      end
      // rotate to W first, then back into the file byte
      for (int d = 0; d < 2; d++) begin
         r = {m[0], m[7:1]};
         st[FLAG_N] = r[7];
         st[FLAG_Z] = (r == 8'h00);
         run_instr({OPC_ROTATE_HI, d[0], 1'b1, 8'h10});
         chk(status_out, st);
         if (d == 0) chk(w_out, r);
         else m = r;
         peek(4'h2, 8'h10, m);
      end
      // subtract into W; W equals the file byte after the two rotates
      {st, r} = sub_ref(m, m, st[FLAG_C]);
      run_instr({OPC_SUBTRACT_HI, 1'b0, 1'b1, 8'h10});
      chk(w_out, r);
      chk(status_out, st);
      peek(4'h2, 8'h10, m);
      // an unknown word runs its four phases and changes nothing
      run_instr(16'h0000);
      chk(w_out, r);
      chk(status_out, st);
      // access bank and indexed offset, boundaries at 5fh and 60h
      foreach (fa[i]) begin
         @(posedge core_clk);
         ext_set_enable <= ex[i];
         run_instr({OPC_FILL_HI, 1'b0, fa[i]});
         if (ex[i] && fa[i] <= INDEXED_LIMIT) peek(4'h0, fa[i] + index_base, FILL_VALUE);
         else peek((fa[i] < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK, fa[i], FILL_VALUE);
      end
      @(posedge core_clk);
      irq_clear_wr <= 1'b1;
      irq_clear <= 3'b001;
      @(posedge core_clk);
      irq_clear_wr <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk({irq_status, irq_out}, 4'b0000);
      // let the watchdog run before sleep so the clear is visible
      @(posedge core_clk);
      wdt_tick <= 1'b1;
      repeat (5) @(posedge core_clk);
      wdt_tick <= 1'b0;
      run_instr(OPC_SLEEP);
      chk({power_down_flag, time_out_flag, sleeping, osc_run}, 4'b0110);
      chk({watchdog_counter, watchdog_post}, 4'h0);
      // a word offered while asleep must be refused
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr_word <= {OPC_FILL_HI, 1'b1, 8'h10};
      for (int k = 0; k < 6; k++) begin
         @(posedge core_clk);
         #1;
         chk(instr_done, 1'b0);
         chk(instr_ready, 1'b0);
      end
      @(posedge core_clk);
      instr_valid <= 1'b0;
      wdt_tick <= 1'b1;
      for (int k = 0; k < 40 && sleeping !== 1'b0; k++) @(posedge core_clk);
      wdt_tick <= 1'b0;
      #1;
      chk({sleeping, osc_run, time_out_flag}, 3'b010);
      run_instr(OPC_SLEEP);
      chk({time_out_flag, power_down_flag}, 2'b10);
      @(posedge core_clk);
      wake_other <= 1'b1;
      for (int k = 0; k < 20 && sleeping !== 1'b0; k++) @(posedge core_clk);
      wake_other <= 1'b0;
      #1;
      chk({sleeping, osc_run, time_out_flag}, 3'b011);
      chk(irq_status, 3'b111);
      @(posedge core_clk);
      irq_enable <= 3'b100;
      repeat (2) @(posedge core_clk);
      #1;
      chk(irq_out, 1'b1);
      @(posedge core_clk);
      irq_clear_wr <= 1'b1;
      irq_clear <= 3'b100;
      @(posedge core_clk);
      irq_clear_wr <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk({irq_status, irq_out}, 4'b0110);
      tally_and_finish();
   end
endmodule // rsse_exec_tb_top
